/* File: verilog/sap_pkg.sv */
package sap_pkg;
    // =========================================================
    // Control register map and fields
    // =========================================================
    localparam logic [7:0] FMT_ADDR = 8'h01;
    localparam logic [7:0] STAT_ADDR = 8'h02;
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam int WL_LSB = 0;
    localparam int JUST_LSB = 4;
    localparam int WIDE_BIT = 6;
    localparam int STAT_FAULT = 0;
    localparam logic [1:0] JUST_LEFT = 2'h0;
    localparam logic [1:0] JUST_RIGHT = 2'h1;
    localparam logic [1:0] JUST_I2S = 2'h2;
    // =========================================================
    // Slot geometry and timing
    // =========================================================
    localparam logic [5:0] SLOT_WIDE = 6'h20;
    localparam logic [5:0] SLOT_NARROW = 6'h10;
    localparam logic [5:0] MSB_IDX = 6'h17;
    localparam logic [11:0] PHASE_SLIP_MCLK = 12'h00a;
    // Divider taps on a free 5-bit cycle counter of sys_clk.
    localparam int MCLK_TAP_512 = 0;
    localparam int MCLK_TAP_256 = 1;
    localparam int BCLK_TAP_WIDE = 3;
    localparam int BCLK_TAP_NARROW = 4;

    function automatic logic [5:0] slot_len(input logic [7:0] f);
        return f[WIDE_BIT] ? SLOT_WIDE : SLOT_NARROW;
    endfunction

    // The narrow mode only exists as 16-bit, left-aligned.
    function automatic logic [5:0] word_len(input logic [7:0] f);
        if (!f[WIDE_BIT]) return 6'h10;
        case (f[WL_LSB+:2])
            2'h0: return 6'h10;
            2'h1: return 6'h12;
            2'h2: return 6'h14;
            default: return 6'h18;
        endcase
    endfunction

    function automatic logic [5:0] first_pos(input logic [7:0] f);
        if (!f[WIDE_BIT]) return 6'h00;
        case (f[JUST_LSB+:2])
            JUST_RIGHT: return SLOT_WIDE - word_len(f);
            JUST_I2S: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction

    function automatic logic left_high(input logic [7:0] f);
        return !(f[WIDE_BIT] && f[JUST_LSB+:2] == JUST_I2S);
    endfunction

    // Returns {valid, bit index into an MSB-aligned 24-bit word}.
    function automatic logic [5:0] slot_index(input logic [7:0] f, input logic [5:0] p);
        logic [5:0] k;
        k = p - first_pos(f);
        if (p >= first_pos(f) && k < word_len(f)) return {1'b1, 5'(MSB_IDX - k)};
        return 6'h00;
    endfunction

    function automatic logic [4:0] mclk_per_bclk(input logic [7:0] f, input logic r512);
        if (f[WIDE_BIT]) return r512 ? 5'h08 : 5'h04;
        return r512 ? 5'h10 : 5'h08;
    endfunction

    // Returns {master clock, bit clock} from the cycle counter.
    function automatic logic [1:0] clk_taps(input logic [7:0] f, input logic r512, input logic [4:0] c);
        return {r512 ? c[MCLK_TAP_512] : c[MCLK_TAP_256], f[WIDE_BIT] ? c[BCLK_TAP_WIDE] : c[BCLK_TAP_NARROW]};
    endfunction
endpackage

/* File: verilog/audio_link_if.sv */
interface audio_link_if;
    // Strap pins.
    logic interface_role_select;
    logic master_clock_ratio_select;
    // Frame and bit clock pins, each driven by one end.
    logic dev_frame_o;
    logic dev_frame_oe;
    logic dev_bit_o;
    logic dev_bit_oe;
    logic host_frame_o;
    logic host_bit_o;
    logic frame_clk;
    logic bit_clk;
    // Master clock pins.
    logic crystal_or_master_clock_in;
    logic crystal_drive_pin;
    logic master_clock_output_pin;
    // Serial data.
    logic serial_in_primary;
    logic serial_in_secondary;
    logic converter_serial_out;
    logic processed_serial_out;
    logic mono_mix_serial_out;

    assign frame_clk = dev_frame_oe ? dev_frame_o : host_frame_o;
    assign bit_clk = dev_bit_oe ? dev_bit_o : host_bit_o;

    modport device (
        input interface_role_select, master_clock_ratio_select, frame_clk, bit_clk,
        input crystal_or_master_clock_in, serial_in_primary, serial_in_secondary,
        output dev_frame_o, dev_frame_oe, dev_bit_o, dev_bit_oe, crystal_drive_pin,
        output master_clock_output_pin, converter_serial_out, processed_serial_out, mono_mix_serial_out
    );
    modport host (
        input interface_role_select, master_clock_ratio_select, frame_clk, bit_clk,
        input master_clock_output_pin, converter_serial_out, processed_serial_out, mono_mix_serial_out,
        output host_frame_o, host_bit_o, crystal_or_master_clock_in, serial_in_primary, serial_in_secondary
    );
endinterface

/* File: verilog/link_partner.sv */
module link_partner (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Link pins.
    audio_link_if.host link,
    // Format, matching the device register.
    input wire logic [7:0] fmt,
    // Words to send, MSB-aligned.
    input wire logic [23:0] in1_left,
    input wire logic [23:0] in1_right,
    input wire logic [23:0] in2_left,
    input wire logic [23:0] in2_right,
    // Words received.
    output logic [23:0] conv_left,
    output logic [23:0] conv_right,
    output logic [23:0] proc_left,
    output logic [23:0] proc_right,
    output logic [23:0] mono_left,
    output logic [23:0] mono_right,
    output logic rx_frame
);
    // =========================================================
    // Synchronisers and clock generation
    // =========================================================
    logic [6:0] meta_q, sync_q;
    logic [4:0] cyc_q;
    logic mclk_q, bit_q, frame_q, bit_prev_q, frame_last_q, chan_q, seen_q;
    logic [5:0] pos_q;
    logic [23:0] w1_q, w2_q, sh0_q, sh1_q, sh2_q;
    logic s1_q, s2_q;
    logic master, bit_now, frame_now, rise, fall, new_phase, left_now;
    logic [5:0] p_d, ix_d, ix;
    logic [23:0] w1_d, w2_d;
    logic [1:0] taps;

    always_ff @(posedge sys_clk) begin
        meta_q <= {link.interface_role_select, link.master_clock_ratio_select, link.frame_clk, link.bit_clk,
                   link.converter_serial_out, link.processed_serial_out, link.mono_mix_serial_out};
        sync_q <= meta_q;
    end

    always_comb begin
        master = sync_q[6];
        taps = sap_pkg::clk_taps(fmt, sync_q[5], cyc_q);
        bit_now = master ? sync_q[3] : bit_q;
        frame_now = master ? sync_q[4] : frame_q;
        rise = bit_now && !bit_prev_q;
        fall = !bit_now && bit_prev_q;
        new_phase = frame_now != frame_last_q;
        left_now = frame_now == sap_pkg::left_high(fmt);
        p_d = new_phase ? 6'h00 : (pos_q == 6'h3f ? pos_q : pos_q + 6'h01);
        w1_d = new_phase ? (left_now ? in1_left : in1_right) : w1_q;
        w2_d = new_phase ? (left_now ? in2_left : in2_right) : w2_q;
        ix_d = sap_pkg::slot_index(fmt, p_d);
        ix = sap_pkg::slot_index(fmt, pos_q);
    end

    // The master clock always runs; bit clock and frame clock only while the device is a slave.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cyc_q <= '0;
            mclk_q <= 1'b0;
            bit_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 5'h01;
            mclk_q <= taps[1];
            bit_q <= master ? 1'b0 : taps[0];
            if (master) begin
                frame_q <= 1'b0;
            end else if (bit_q && !taps[0] && pos_q == sap_pkg::slot_len(fmt) - 6'h01) begin
                frame_q <= !frame_q;
            end
        end
    end

    assign link.crystal_or_master_clock_in = mclk_q;
    assign link.host_bit_o = bit_q;
    assign link.host_frame_o = frame_q;
    assign link.serial_in_primary = s1_q;
    assign link.serial_in_secondary = s2_q;

    // =========================================================
    // Serial data
    // =========================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_prev_q <= 1'b0;
            frame_last_q <= 1'b0;
            chan_q <= 1'b0;
            seen_q <= 1'b0;
            pos_q <= '0;
            {w1_q, w2_q, sh0_q, sh1_q, sh2_q} <= '0;
            {conv_left, conv_right, proc_left, proc_right, mono_left, mono_right} <= '0;
            {s1_q, s2_q, rx_frame} <= '0;
        end else begin
            bit_prev_q <= bit_now;
            rx_frame <= 1'b0;
            if (rise && ix[5]) begin
                sh0_q[ix[4:0]] <= sync_q[2];
                sh1_q[ix[4:0]] <= sync_q[1];
                sh2_q[ix[4:0]] <= sync_q[0];
            end
            if (fall) begin
                pos_q <= p_d;
                w1_q <= w1_d;
                w2_q <= w2_d;
                s1_q <= ix_d[5] && w1_d[ix_d[4:0]];
                s2_q <= ix_d[5] && w2_d[ix_d[4:0]];
                if (new_phase) begin
                    frame_last_q <= frame_now;
                    chan_q <= left_now;
                    seen_q <= 1'b1;
                    {sh0_q, sh1_q, sh2_q} <= '0;
                    if (chan_q) begin
                        {conv_left, proc_left, mono_left} <= {sh0_q, sh1_q, sh2_q};
                    end else begin
                        {conv_right, proc_right, mono_right} <= {sh0_q, sh1_q, sh2_q};
                        rx_frame <= seen_q;
                    end
                end
            end
        end
    end
endmodule // link_partner

/* File: verilog/serial_audio_port.sv */
module serial_audio_port (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Link pins.
    audio_link_if.device link,
    // Device pins outside the link.
    input wire logic chip_reset_n,
    input wire logic power_down_input,
    // Control register port.
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_addr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl_rdata,
    // Words to send, MSB-aligned.
    input wire logic [23:0] adc_left,
    input wire logic [23:0] adc_right,
    input wire logic [23:0] proc_left,
    input wire logic [23:0] proc_right,
    // Words received, MSB-aligned.
    output logic [23:0] prim_left,
    output logic [23:0] prim_right,
    output logic [23:0] sec_left,
    output logic [23:0] sec_right,
    output logic rx_frame
);
    // =========================================================
    // Pin synchronisers
    // =========================================================
    logic [8:0] meta_q, sync_q;

    always_ff @(posedge sys_clk) begin
        meta_q <= {link.interface_role_select, link.master_clock_ratio_select, power_down_input,
                   chip_reset_n, link.frame_clk, link.bit_clk, link.crystal_or_master_clock_in,
                   link.serial_in_primary, link.serial_in_secondary};
        sync_q <= meta_q;
    end

    logic master, r512, init, halt;

    always_comb begin
        master = sync_q[8];
        r512 = sync_q[7];
        init = rst || !sync_q[5];
        halt = init || sync_q[6];
    end

    // =========================================================
    // Control register
    // =========================================================
    logic [7:0] fmt_q;
    logic fault_q;
    logic fault;

    always_ff @(posedge sys_clk) begin
        if (init) begin
            fmt_q <= sap_pkg::FMT_RESET;
        end else if (ctrl_wr && ctrl_addr == sap_pkg::FMT_ADDR) begin
            fmt_q <= ctrl_wdata;
        end
    end

    // A slip seen in the same cycle as a clearing write stays recorded.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault || (fault_q && !(ctrl_wr && ctrl_addr == sap_pkg::STAT_ADDR
                       && ctrl_wdata[sap_pkg::STAT_FAULT]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            ctrl_rdata <= '0;
        end else if (ctrl_addr == sap_pkg::FMT_ADDR) begin
            ctrl_rdata <= fmt_q;
        end else if (ctrl_addr == sap_pkg::STAT_ADDR) begin
            ctrl_rdata <= {5'h00, master, sync_q[6], fault_q};
        end else begin
            ctrl_rdata <= '0;
        end
    end

    // =========================================================
    // Clock generation in master mode
    // =========================================================
    logic [4:0] cyc_q;
    logic mclk_q, gbit_q, gframe_q, oe_q, xdrv_q;
    logic [5:0] pos_q;
    logic [1:0] taps;

    assign taps = sap_pkg::clk_taps(fmt_q, r512, cyc_q);

    // Bit and frame clocks are divided from sys_clk so they stay in step with the shifter.
    always_ff @(posedge sys_clk) begin
        if (halt || !master) begin
            cyc_q <= '0;
            mclk_q <= 1'b0;
            gbit_q <= 1'b0;
            gframe_q <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 5'h01;
            mclk_q <= taps[1];
            gbit_q <= taps[0];
            if (gbit_q && !taps[0] && pos_q == sap_pkg::slot_len(fmt_q) - 6'h01) begin
                gframe_q <= !gframe_q;
            end
        end
    end

    // The crystal drive is the inverted reference in running master mode, low in slave mode or halt; the reference itself only feeds the
    // clock multiplier, which lies outside this port.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            oe_q <= 1'b0;
            xdrv_q <= 1'b0;
        end else begin
            oe_q <= master;
            xdrv_q <= master && !halt && !sync_q[2];
        end
    end

    assign link.dev_frame_o = gframe_q;
    assign link.dev_bit_o = gbit_q;
    assign link.dev_frame_oe = oe_q;
    assign link.dev_bit_oe = oe_q;
    assign link.master_clock_output_pin = mclk_q;
    assign link.crystal_drive_pin = xdrv_q;

    // =========================================================
    // Slot tracking and phase slip
    // =========================================================
    logic bit_prev_q, frame_last_q, chan_q, seen_q;
    logic [6:0] rises_q, slip;
    logic bit_now, frame_now, rise, fall, new_phase, left_now;
    logic [5:0] p_d, ix_d, ix;
    logic [11:0] slip_mclk;
    logic [23:0] cw_d, pw_d, mw_d;
    logic [23:0] cw_q, pw_q, mw_q, mono_q, sh1_q, sh2_q;
    logic [24:0] mix;
    logic o0_q, o1_q, o2_q;

    always_comb begin
        bit_now = master ? gbit_q : sync_q[3];
        frame_now = master ? gframe_q : sync_q[4];
        rise = bit_now && !bit_prev_q;
        fall = !bit_now && bit_prev_q;
        new_phase = frame_now != frame_last_q;
        left_now = frame_now == sap_pkg::left_high(fmt_q);
        p_d = new_phase ? 6'h00 : (pos_q == 6'h3f ? pos_q : pos_q + 6'h01);
        ix_d = sap_pkg::slot_index(fmt_q, p_d);
        ix = sap_pkg::slot_index(fmt_q, pos_q);
        cw_d = new_phase ? (left_now ? adc_left : adc_right) : cw_q;
        pw_d = new_phase ? (left_now ? proc_left : proc_right) : pw_q;
        mw_d = new_phase ? mono_q : mw_q;
        slip = rises_q > {1'b0, sap_pkg::slot_len(fmt_q)} ? rises_q - {1'b0, sap_pkg::slot_len(fmt_q)}
               : {1'b0, sap_pkg::slot_len(fmt_q)} - rises_q;
        slip_mclk = 12'(slip * sap_pkg::mclk_per_bclk(fmt_q, r512));
        fault = fall && new_phase && !master && seen_q && slip_mclk > sap_pkg::PHASE_SLIP_MCLK;
        mix = {prim_left[23], prim_left} + {sh1_q[23], sh1_q};
    end

    // =========================================================
    // Serial shifter shared by all five data pins
    // =========================================================
    // One slot position drives every pin, so the format cannot differ between them.
    always_ff @(posedge sys_clk) begin
        if (halt || fault) begin
            bit_prev_q <= 1'b0;
            frame_last_q <= 1'b0;
            chan_q <= 1'b0;
            seen_q <= 1'b0;
            pos_q <= '0;
            rises_q <= '0;
            {cw_q, pw_q, mw_q, mono_q, sh1_q, sh2_q} <= '0;
            {prim_left, prim_right, sec_left, sec_right} <= '0;
            {o0_q, o1_q, o2_q, rx_frame} <= '0;
        end else begin
            bit_prev_q <= bit_now;
            rx_frame <= 1'b0;
            if (rise) begin
                rises_q <= rises_q == 7'h7f ? rises_q : rises_q + 7'h01;
                if (ix[5]) begin
                    sh1_q[ix[4:0]] <= sync_q[1];
                    sh2_q[ix[4:0]] <= sync_q[0];
                end
            end
            if (fall) begin
                pos_q <= p_d;
                cw_q <= cw_d;
                pw_q <= pw_d;
                mw_q <= mw_d;
                o0_q <= ix_d[5] && cw_d[ix_d[4:0]];
                o1_q <= ix_d[5] && pw_d[ix_d[4:0]];
                o2_q <= ix_d[5] && mw_d[ix_d[4:0]];
                if (new_phase) begin
                    frame_last_q <= frame_now;
                    chan_q <= left_now;
                    seen_q <= 1'b1;
                    rises_q <= '0;
                    {sh1_q, sh2_q} <= '0;
                    if (chan_q) begin
                        prim_left <= sh1_q;
                        sec_left <= sh2_q;
                    end else begin
                        prim_right <= sh1_q;
                        sec_right <= sh2_q;
                        mono_q <= mix[24:1];
                        rx_frame <= seen_q;
                    end
                end
            end
        end
    end

    assign link.converter_serial_out = o0_q;
    assign link.processed_serial_out = o1_q;
    assign link.mono_mix_serial_out = o2_q;
endmodule // serial_audio_port

/* File: tb/audio_link_sva.sv */
module audio_link_sva (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Straps and clock pins.
    input wire logic interface_role_select,
    input wire logic master_clock_ratio_select,
    input wire logic dev_frame_oe,
    input wire logic dev_bit_oe,
    input wire logic frame_clk,
    input wire logic bit_clk,
    input wire logic crystal_or_master_clock_in,
    input wire logic crystal_drive_pin,
    input wire logic master_clock_output_pin,
    // Serial data outputs.
    input wire logic converter_serial_out,
    input wire logic processed_serial_out,
    input wire logic mono_mix_serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // =========================================================
    // Strap settling
    // =========================================================
    // Straps pass a synchroniser, so pin checks wait until they have been steady a while.
    logic [1:0] strap_q;
    logic [3:0] age_q;
    logic master;
    logic slave;
    always_ff @(posedge sys_clk) begin
        strap_q <= {interface_role_select, master_clock_ratio_select};
    end
    always_ff @(posedge sys_clk) begin
        if (rst || strap_q != {interface_role_select, master_clock_ratio_select}) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    assign master = age_q == 4'hf && interface_role_select;
    assign slave = age_q == 4'hf && !interface_role_select;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // =========================================================
    // Assertions
    // =========================================================
    slave_pins_a: assert property (slave |-> !dev_frame_oe && !dev_bit_oe && !master_clock_output_pin)
        else $error("slave end drives a clock pin");
    master_oe_a: assert property (master |-> dev_frame_oe && dev_bit_oe)
        else $error("master end does not drive its clock pins");
    mclk_fast_a: assert property (master && master_clock_ratio_select |->
        master_clock_output_pin != $past(master_clock_output_pin))
        else $error("fast master clock does not toggle every cycle");
    mclk_slow_a: assert property (master && !master_clock_ratio_select && $changed(master_clock_output_pin)
        |=> $stable(master_clock_output_pin) ##1 $changed(master_clock_output_pin))
        else $error("slow master clock period is not four cycles");
    xtal_follow_a: assert property (master && $changed(crystal_or_master_clock_in) |->
        ##[1:4] $changed(crystal_drive_pin))
        else $error("crystal drive does not follow the reference");
    frame_edge_a: assert property ($changed(frame_clk) |-> !bit_clk)
        else $error("frame clock moved while bit clock high");
    data_hold_a: assert property (master && bit_clk |->
        $stable({converter_serial_out, processed_serial_out, mono_mix_serial_out}))
        else $error("serial output changed while bit clock high");
    data_launch_a: assert property (master && $changed(converter_serial_out) |->
        $past(bit_clk, 2) && !$past(bit_clk))
        else $error("serial output not launched after falling bit clock");
    cover property (master && $changed(frame_clk));
    cover property (slave && $changed(frame_clk));
    cover property (master && !master_clock_ratio_select && $rose(master_clock_output_pin));
endmodule // audio_link_sva

/* File: tb/tb_serial_audio_port.sv */
module tb_serial_audio_port;
    timeunit 1ns;
    timeprecision 100ps;
    // =========================================================
    // Signals and instances
    // =========================================================
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic chip_reset_n = 1'b1;
    logic power_down_input = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [7:0] ctrl_addr = 8'h00;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [7:0] ctrl_rdata;
    logic [7:0] fmt = 8'h00;
    logic [23:0] tx [4];
    logic [23:0] src [4];
    logic [23:0] dv [4];
    logic [23:0] pv [6];
    logic rx_frame;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    audio_link_if audio_link_if_i ();
    serial_audio_port serial_audio_port_i (.sys_clk(sys_clk), .rst(rst), .link(audio_link_if_i.device),
        .chip_reset_n(chip_reset_n), .power_down_input(power_down_input), .ctrl_wr(ctrl_wr),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .adc_left(tx[0]),
        .adc_right(tx[1]), .proc_left(tx[2]), .proc_right(tx[3]), .prim_left(dv[0]), .prim_right(dv[1]),
        .sec_left(dv[2]), .sec_right(dv[3]), .rx_frame(rx_frame));
    link_partner link_partner_i (.sys_clk(sys_clk), .rst(rst), .link(audio_link_if_i.host), .fmt(fmt),
        .in1_left(src[0]), .in1_right(src[1]), .in2_left(src[2]), .in2_right(src[3]), .conv_left(pv[0]),
        .conv_right(pv[1]), .proc_left(pv[2]), .proc_right(pv[3]), .mono_left(pv[4]), .mono_right(pv[5]),
        .rx_frame());
    audio_link_sva audio_link_sva_i (.sys_clk(sys_clk), .rst(rst),
        .interface_role_select(audio_link_if_i.interface_role_select),
        .master_clock_ratio_select(audio_link_if_i.master_clock_ratio_select),
        .dev_frame_oe(audio_link_if_i.dev_frame_oe), .dev_bit_oe(audio_link_if_i.dev_bit_oe),
        .frame_clk(audio_link_if_i.frame_clk), .bit_clk(audio_link_if_i.bit_clk),
        .crystal_or_master_clock_in(audio_link_if_i.crystal_or_master_clock_in),
        .crystal_drive_pin(audio_link_if_i.crystal_drive_pin),
        .master_clock_output_pin(audio_link_if_i.master_clock_output_pin),
        .converter_serial_out(audio_link_if_i.converter_serial_out),
        .processed_serial_out(audio_link_if_i.processed_serial_out),
        .mono_mix_serial_out(audio_link_if_i.mono_mix_serial_out));
    always #4 sys_clk = ~sys_clk;
    // Ceiling is about a third above the expected run length.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 95000) begin
            fail_count++;
            $display("[ERR] timeout after %0d cycles", cycles);
            print_verdict();
        end
    end
    // =========================================================
    // Tasks
    // =========================================================
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        ctrl_wr = 1'b1;
        ctrl_addr = a;
        ctrl_wdata = d;
        @(posedge sys_clk) #1;
        ctrl_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) #1;
        ctrl_addr = a;
        @(posedge sys_clk) #1;
        check($sformatf("reg %h", a), {16'h0, ctrl_rdata}, {16'h0, e});
    endtask
    task automatic frames(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge sys_clk) #1;
                k++;
            end while (rx_frame !== 1'b1 && k < 2000);
            if (k >= 2000) check("frame wait", 24'h0, 24'h1);
        end
    endtask
    function automatic logic [23:0] cut(input logic [23:0] v, input logic [7:0] f);
        int n;
        n = !f[sap_pkg::WIDE_BIT] ? 16 : (f[1:0] == 2'h3 ? 24 : 16 + 2 * f[1:0]);
        return v & ~(24'hffffff >> n);
    endfunction
    // Every run restarts the link so each setting starts from reset; straps reach the device through its synchroniser at any time.
    task automatic run(input logic [7:0] f, input logic role, input logic ratio);
        logic [23:0] mono;
        @(posedge sys_clk) #1;
        rst = 1'b1;
        audio_link_if_i.interface_role_select = role;
        audio_link_if_i.master_clock_ratio_select = ratio;
        fmt = f;
        for (int i = 0; i < 4; i++) begin
            tx[i] = {f, 8'h5a + 8'(i), ~f};
            src[i] = (24'h1e3c5a + 24'(i) * 24'h070b0d) ^ {8'h0, f, f};
        end
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        wr(sap_pkg::FMT_ADDR, f);
        rdchk(sap_pkg::FMT_ADDR, f);
        frames(2);
        wr(sap_pkg::STAT_ADDR, 8'h01);
        frames(2);
        rdchk(sap_pkg::STAT_ADDR, {5'h0, role, 2'h0});
        for (int i = 0; i < 4; i++) begin
            check($sformatf("rx %0d", i), dv[i], cut(src[i], f));
            check($sformatf("tx %0d", i), pv[i], cut(tx[i], f));
        end
        mono = cut(24'((25'(cut(src[0], f)) + 25'(cut(src[1], f))) >> 1), f);
        check("mono left", pv[4], mono);
        check("mono right", pv[5], mono);
    endtask
    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        logic quiet;
        audio_link_if_i.interface_role_select = 1'b1;
        audio_link_if_i.master_clock_ratio_select = 1'b1;
        for (int i = 0; i < 4; i++) begin
            tx[i] = 24'h0;
            src[i] = 24'h0;
        end
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        rdchk(sap_pkg::FMT_ADDR, sap_pkg::FMT_RESET);
        wr(8'h05, 8'hff);
        rdchk(8'h05, 8'h00);
        rdchk(sap_pkg::FMT_ADDR, sap_pkg::FMT_RESET);
        for (int m = 0; m < 13; m++) begin
            run(m == 0 ? 8'h00 : 8'h40 | 8'(((m - 1) % 3) << 4) | 8'((m - 1) / 3), 1'b1, m[0]);
        end
        run(8'h00, 1'b0, 1'b1);
        run(8'h63, 1'b0, 1'b0);
        // The far end now frames 16-bit phases against a 32-bit device setting.
        fmt = 8'h00;
        repeat (3000) @(posedge sys_clk);
        rdchk(sap_pkg::STAT_ADDR, 8'h01);
        fmt = 8'h63;
        @(posedge sys_clk) #1;
        power_down_input = 1'b1;
        repeat (4) @(posedge sys_clk);
        // Clear the slip flag once power down has frozen the shifter, so no late slip sets it again.
        wr(sap_pkg::STAT_ADDR, 8'h01);
        rdchk(sap_pkg::STAT_ADDR, 8'h02);
        quiet = 1'b0;
        repeat (1200) begin
            @(posedge sys_clk) #1;
            quiet = quiet | audio_link_if_i.converter_serial_out | audio_link_if_i.processed_serial_out;
            quiet = quiet | audio_link_if_i.mono_mix_serial_out;
        end
        check("power down outputs", {23'h0, quiet}, 24'h0);
        rdchk(sap_pkg::FMT_ADDR, 8'h63);
        power_down_input = 1'b0;
        chip_reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chip_reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        rdchk(sap_pkg::FMT_ADDR, sap_pkg::FMT_RESET);
        print_verdict();
    end
endmodule // tb_serial_audio_port
